//--- find_sup_pkg.sv
/*
 * Constants for the commutation find supervisor: register addresses,
 * reset values, range limits, routine state codes and timing counts.
 * Assumes a single 200 MHz clock and the drive's register port.
 */
// Summary of operation
// - Monitoring waits until velocity exceeds threshold.
// - Cancel command drops a pending find request.
// - Cancel stops routine, state forced idle.
// - Cancel acts the same for any feedback.
// - Excess movement while finding raises fault.
// - Movement limit 0 to 90, reset 15.
// - Request when idle and disabled arms routine.
// - Error after persist time; zero disables monitoring.
package find_sup_pkg;
   // ******************************************************************
   // Register addresses, taken as printed.
   // ******************************************************************
   localparam logic [15:0] ADDR_MAX_MOVE   = 16'h037C;  // Movement limit.
   localparam logic [15:0] ADDR_CANCEL     = 16'h069E;  // Cancel command.
   localparam logic [15:0] ADDR_VEL_THRESH = 16'h06A6;  // Velocity threshold.

   // ******************************************************************
   // Reset values and ranges.
   // ******************************************************************
   localparam logic [63:0] MAX_MOVE_RESET  = 64'h0000_0000_0000_000F;  // 15 deg.
   localparam logic [63:0] MAX_MOVE_LIMIT  = 64'h0000_0000_0000_005A;  // 90 deg.
   localparam logic [31:0] VEL_THRESH_RESET = 32'h0000_0000;            // Zero.
   // Rotary limits: rpm, rps, deg/s, PIN/POUT.
   localparam logic [31:0] ROT_LIMIT_0 = 32'h0000_3A98;  // 15000.
   localparam logic [31:0] ROT_LIMIT_1 = 32'h0000_00FA;  // 250.
   localparam logic [31:0] ROT_LIMIT_2 = 32'h0001_5F90;  // 90000.
   localparam logic [31:0] ROT_LIMIT_3 = 32'h0000_04E2;  // 1250.
   // Linear limits: counts/s, mm/s, um/s, PIN/POUT.
   localparam logic [31:0] LIN_LIMIT_0 = 32'h0400_0000;  // 67108864.
   localparam logic [31:0] LIN_LIMIT_1 = 32'h0000_1F40;  // 8000.
   localparam logic [31:0] LIN_LIMIT_2 = 32'h0009_006E;  // 589934.
   localparam logic [31:0] LIN_LIMIT_3 = 32'h0000_04E2;  // 1250.

   // ******************************************************************
   // Timing.
   // ******************************************************************
   localparam int unsigned CLK_PERIOD_PS = 5000;        // 200 MHz clock.
   localparam int unsigned MS_PS         = 1000000000;  // One millisecond.
   localparam int unsigned CYCLES_PER_MS = MS_PS / CLK_PERIOD_PS;

   // ******************************************************************
   // Routine state codes as reported.
   // ******************************************************************
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,  // Nothing pending.
      ST_ARMED   = 2'b01,  // Runs at next enable.
      ST_RUNNING = 2'b10,  // Finding commutation.
      ST_DONE    = 2'b11   // Found; monitoring phase.
   } find_state_type;
endpackage

//--- commutation_find_supervisor.sv
/*
 * Commutation find supervisor: find request and cancel handling, movement
 * limit fault, and velocity-gated commutation monitoring with persist time.
 * Assumes synchronous inputs, a synchronous active-high reset and a simple
 * addressed register port with one-cycle write and read strobes.
 */
`timescale 1ns/1ps
module commutation_find_supervisor #(
   parameter int unsigned CYCLES_PER_MS = find_sup_pkg::CYCLES_PER_MS
) (
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   // Register port.
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   input  wire logic [15:0]          reg_addr_i,
   input  wire logic [63:0]          reg_wdata_i,
   output logic      [63:0]          reg_rdata_o,
   output logic                      reg_rvalid_o,
   // Drive and routine signals.
   input  wire logic                 find_request_command_i,
   input  wire logic                 drive_enable_i,
   input  wire logic                 find_complete_i,
   input  wire logic signed [63:0]   find_movement_i,
   input  wire logic signed [31:0]   motor_velocity_i,
   input  wire logic                 linear_axis_i,
   input  wire logic [1:0]           rotary_velocity_unit_select_i,
   input  wire logic [1:0]           linear_velocity_unit_select_i,
   input  wire logic [15:0]          monitor_error_persist_time_i,
   input  wire logic                 commutation_error_raw_i,
   // Status outputs.
   output logic [1:0]                find_routine_state_o,
   output logic                      find_active_o,
   output logic                      monitor_active_o,
   output logic                      monitor_error_o,
   output logic                      too_much_movement_fault_o
);
   // ******************************************************************
   // Declarations.
   // ******************************************************************
   find_sup_pkg::find_state_type state;        // Routine state.
   logic [63:0]  max_move;                      // Movement limit, degrees.
   logic [31:0]  vel_thresh;                    // Velocity threshold.
   logic [31:0]  unit_limit;                    // Threshold ceiling for unit.
   logic [32:0]  vel_abs;                       // Velocity magnitude.
   logic [64:0]  move_abs;                      // Movement magnitude.
   logic         vel_exceeds;                   // Magnitude above threshold.
   logic         over_move;                     // Movement above limit.
   logic         cancel;                        // Cancel command write.
   logic         enable_d;                      // Enable one cycle ago.
   logic [31:0]  ms_count;                      // Cycles within a millisecond.
   logic [15:0]  persist_ms;                    // Milliseconds of error seen.
   logic         ms_tick;                       // One millisecond elapsed.

   // Magnitudes are one bit wider so the most negative value cannot wrap.
   // magnitude of velocity
   assign vel_abs  = motor_velocity_i[31] ? 33'(-$signed({motor_velocity_i[31], motor_velocity_i}))
                                          : {1'b0, motor_velocity_i};
   assign move_abs = find_movement_i[63] ? 65'(-$signed({find_movement_i[63], find_movement_i}))
                                         : {1'b0, find_movement_i};
   assign vel_exceeds = vel_abs > {1'b0, vel_thresh};
   assign over_move   = move_abs > {1'b0, max_move};
   assign cancel      = reg_wr_i && (reg_addr_i == find_sup_pkg::ADDR_CANCEL);
   assign ms_tick     = (ms_count == CYCLES_PER_MS - 1);

   // Ceiling of the threshold for the active unit selection.
   // unit dependent ceiling
   always_comb begin
      unique case (linear_axis_i ? linear_velocity_unit_select_i
                                 : rotary_velocity_unit_select_i)
         2'd0: unit_limit = linear_axis_i ? find_sup_pkg::LIN_LIMIT_0 : find_sup_pkg::ROT_LIMIT_0;
         2'd1: unit_limit = linear_axis_i ? find_sup_pkg::LIN_LIMIT_1 : find_sup_pkg::ROT_LIMIT_1;
         2'd2: unit_limit = linear_axis_i ? find_sup_pkg::LIN_LIMIT_2 : find_sup_pkg::ROT_LIMIT_2;
         2'd3: unit_limit = linear_axis_i ? find_sup_pkg::LIN_LIMIT_3 : find_sup_pkg::ROT_LIMIT_3;
      endcase
   end

   // ******************************************************************
   // Parameter registers.
   // ******************************************************************
   // Writes are clamped into range; negative values land on zero.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         max_move   <= find_sup_pkg::MAX_MOVE_RESET;
         vel_thresh <= find_sup_pkg::VEL_THRESH_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == find_sup_pkg::ADDR_MAX_MOVE) begin
            if (reg_wdata_i[63])
               max_move <= 64'h0;
            else if (reg_wdata_i > find_sup_pkg::MAX_MOVE_LIMIT)
               max_move <= find_sup_pkg::MAX_MOVE_LIMIT;
            else
               max_move <= reg_wdata_i;
         end
         if (reg_addr_i == find_sup_pkg::ADDR_VEL_THRESH) begin
            if (reg_wdata_i[63])
               vel_thresh <= 32'h0;
            else if (reg_wdata_i > {32'h0, unit_limit})
               vel_thresh <= unit_limit;
            else
               vel_thresh <= reg_wdata_i[31:0];
         end
      end
   end

   // Read data; the cancel command and unmapped addresses read as zero.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o  <= 64'h0;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i && reg_addr_i == find_sup_pkg::ADDR_MAX_MOVE)
            reg_rdata_o <= max_move;
         else if (reg_rd_i && reg_addr_i == find_sup_pkg::ADDR_VEL_THRESH)
            reg_rdata_o <= {32'h0, vel_thresh};
         else
            reg_rdata_o <= 64'h0;
      end
   end

   // ******************************************************************
   // Routine state.
   // ******************************************************************
   // Cancel outranks every other event; a fault or a disable ends a run.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state    <= find_sup_pkg::ST_IDLE;
         enable_d <= 1'b0;
      end else begin
         enable_d <= drive_enable_i;
         if (cancel) begin
            state <= find_sup_pkg::ST_IDLE;
         end else begin
            unique case (state)
               find_sup_pkg::ST_IDLE: begin
                  if (find_request_command_i && !drive_enable_i)
                     state <= find_sup_pkg::ST_ARMED;
               end
               find_sup_pkg::ST_ARMED: begin
                  if (drive_enable_i && !enable_d)
                     state <= find_sup_pkg::ST_RUNNING;
               end
               find_sup_pkg::ST_RUNNING: begin
                  if (over_move || !drive_enable_i)
                     state <= find_sup_pkg::ST_IDLE;
                  else if (find_complete_i)
                     state <= find_sup_pkg::ST_DONE;
               end
               find_sup_pkg::ST_DONE: begin
                  if (find_request_command_i && !drive_enable_i)
                     state <= find_sup_pkg::ST_ARMED;
               end
            endcase
         end
      end
   end

   // The routine state and find-active outputs follow the state register one cycle later; a cancel clears them on the same edge as the state.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         find_routine_state_o <= 2'b00;
         find_active_o        <= 1'b0;
      end else begin
         find_routine_state_o <= cancel ? 2'b00 : state;
         find_active_o        <= !cancel && (state == find_sup_pkg::ST_RUNNING);
      end
   end

   // Movement fault: sticky until a new request arrives while the routine is idle.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         too_much_movement_fault_o <= 1'b0;
      else if (state == find_sup_pkg::ST_RUNNING && over_move && !cancel)
         too_much_movement_fault_o <= 1'b1;
      else if (find_request_command_i && state == find_sup_pkg::ST_IDLE)
         too_much_movement_fault_o <= 1'b0;
   end

   // ******************************************************************
   // Commutation monitoring.
   // ******************************************************************
   // Activation latches once the threshold is passed after a find.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         monitor_active_o <= 1'b0;
      else if (cancel || state != find_sup_pkg::ST_DONE || monitor_error_persist_time_i == 16'h0)
         monitor_active_o <= 1'b0;
      else if (vel_exceeds)
         monitor_active_o <= 1'b1;
   end

   // Millisecond base and persistence count of a raw error.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !monitor_active_o || !commutation_error_raw_i) begin
         ms_count   <= 32'h0;
         persist_ms <= 16'h0;
      end else if (ms_tick) begin
         ms_count <= 32'h0;
         if (persist_ms != 16'hFFFF)
            persist_ms <= persist_ms + 16'h1;
      end else begin
         ms_count <= ms_count + 32'h1;
      end
   end

   // Error flag: sticky until monitoring drops.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !monitor_active_o)
         monitor_error_o <= 1'b0;
      else if (commutation_error_raw_i && persist_ms >= monitor_error_persist_time_i)
         monitor_error_o <= 1'b1;
   end

   // ******************************************************************
   // Assertions.
   // ******************************************************************
   sequence seq_cancel;
      cancel;
   endsequence
   sequence seq_idle_out;
      find_routine_state_o == 2'b00 && !find_active_o;
   endsequence

   AST_MON_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(monitor_active_o) |-> $past(vel_exceeds))
      else $error("Monitoring started without exceeding threshold.");
   AST_THRESH_CEIL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && reg_addr_i == find_sup_pkg::ADDR_VEL_THRESH) |=> vel_thresh <= $past(unit_limit))
      else $error("Threshold above unit ceiling.");
   AST_CANCEL_DROPS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (seq_cancel and state == find_sup_pkg::ST_ARMED) |=> state == find_sup_pkg::ST_IDLE ##1 !find_active_o)
      else $error("Pending request survived cancel.");
   AST_CANCEL_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      seq_cancel |=> seq_idle_out)
      else $error("Cancel did not force idle.");
   AST_CANCEL_RUN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (seq_cancel and state == find_sup_pkg::ST_RUNNING) |=> state == find_sup_pkg::ST_IDLE)
      else $error("Running routine not stopped by cancel.");
   AST_MOVE_FAULT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state == find_sup_pkg::ST_RUNNING && over_move && !cancel) |=> too_much_movement_fault_o && state == find_sup_pkg::ST_IDLE)
      else $error("Excess movement did not fault.");
   AST_MOVE_RANGE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      max_move <= find_sup_pkg::MAX_MOVE_LIMIT)
      else $error("Movement limit out of range.");
   AST_ARM: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (find_request_command_i && state == find_sup_pkg::ST_IDLE && !drive_enable_i && !cancel)
      |=> state == find_sup_pkg::ST_ARMED
          ##1 find_routine_state_o == ($past(cancel) ? 2'b00 : 2'b01))
      else $error("Request did not arm routine.");
   AST_PERSIST_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (monitor_error_persist_time_i == 16'h0) |=> !monitor_active_o)
      else $error("Monitoring active with zero persist time.");
   AST_NEG_VEL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (state == find_sup_pkg::ST_DONE && !cancel && monitor_error_persist_time_i != 16'h0
       && motor_velocity_i[31] && vel_exceeds) |=> monitor_active_o)
      else $error("Negative velocity did not activate monitoring.");
endmodule

//--- motor_model.sv
/* Servo motor and feedback model for the find supervisor bench.
   Assumes the bench clock and the design's find_active status level. */
`timescale 1ns/1ps
module motor_model (
   // Clock.
   input  wire logic               clk_i,
   // Controls from the bench and the design.
   input  wire logic               find_active_i,
   input  wire logic signed [63:0] move_i,
   input  wire logic [7:0]         settle_i,
   // Feedback to the design.
   output logic signed [63:0]      find_movement_o,
   output logic                    find_complete_o
);
   logic [7:0] age;  // Cycles spent in the routine.
   // ***************************************************************
   // Routine age, restarted whenever the routine is not running.
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      age <= find_active_i ? age + 8'h01 : 8'h00;
   end
   // Travel shows only while the routine moves the shaft.
   assign find_movement_o = find_active_i ? move_i : 64'sh0;
   // A large settle time gives a slow find, zero a prompt one.
   assign find_complete_o = find_active_i && (age >= settle_i);
endmodule

//--- commutation_find_supervisor_tb.sv
/* Self-checking bench for the commutation find supervisor.
   Assumes the motor model beside it and a short millisecond count. */
`timescale 1ns/1ps
module commutation_find_supervisor_tb;
   logic               clk_i, sys_rst_i, reg_wr_i, reg_rd_i, req, en, lin, raw;
   logic               rvalid, fact, mact, merr, fault, fcomp;
   logic [15:0]        addr, persist;
   logic [63:0]        wdata, rdata, v;
   logic signed [63:0] move, mvmt;
   logic signed [31:0] vel;
   logic [1:0]         rot_u, lin_u, st;
   logic [7:0]         settle;
   logic [31:0]        seed, t;
   logic [31:0]        cyc = 32'h0;
   int                 n_mismatch, n_tests;

   commutation_find_supervisor #(.CYCLES_PER_MS(4)) u_dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .find_request_command_i(req), .drive_enable_i(en), .find_complete_i(fcomp),
      .find_movement_i(mvmt), .motor_velocity_i(vel), .linear_axis_i(lin),
      .rotary_velocity_unit_select_i(rot_u), .linear_velocity_unit_select_i(lin_u),
      .monitor_error_persist_time_i(persist), .commutation_error_raw_i(raw),
      .find_routine_state_o(st), .find_active_o(fact), .monitor_active_o(mact),
      .monitor_error_o(merr), .too_much_movement_fault_o(fault));
   motor_model u_motor (.clk_i(clk_i), .find_active_i(fact), .move_i(move),
      .settle_i(settle), .find_movement_o(mvmt), .find_complete_o(fcomp));

   // Clock of 5 ns period.
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Hang guard: counts cycles and closes the run at the ceiling.
   always @(posedge clk_i) begin
      cyc <= cyc + 32'h1;
      if (cyc == 32'd3000) begin
         n_mismatch++;
         summarize();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected movement limit after clamping.
   function automatic logic [63:0] lim_exp(input logic signed [63:0] x);
      return (x < 0) ? 64'h0 : (x > 90) ? find_sup_pkg::MAX_MOVE_LIMIT : x;
   endfunction
   // Expected ceiling of the threshold for an axis kind and unit code.
   function automatic logic [63:0] ceil_exp(input logic l, input logic [1:0] u);
      case (u)
         2'd0: return l ? find_sup_pkg::LIN_LIMIT_0 : find_sup_pkg::ROT_LIMIT_0;
         2'd1: return l ? find_sup_pkg::LIN_LIMIT_1 : find_sup_pkg::ROT_LIMIT_1;
         2'd2: return l ? find_sup_pkg::LIN_LIMIT_2 : find_sup_pkg::ROT_LIMIT_2;
         default: return l ? find_sup_pkg::LIN_LIMIT_3 : find_sup_pkg::ROT_LIMIT_3;
      endcase
   endfunction

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_i);
         #1;
      end
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [63:0] d);
      addr = a;
      wdata = d;
      reg_wr_i = 1'b1;
      tick(1);
      reg_wr_i = 1'b0;
   endtask
   // Read: answer is sampled once the strobe edge has landed.
   // An idle cycle follows, so back-to-back reads never drop and raise the strobe at once.
   task automatic rd(input logic [15:0] a, input logic [63:0] e);
      addr = a;
      reg_rd_i = 1'b1;
      tick(1);
      reg_rd_i = 1'b0;
      chk({63'h0, rvalid}, 64'h1);
      chk(rdata, e);
      tick(1);
   endtask
   task automatic arm();
      req = 1'b1;
      tick(1);
      req = 1'b0;
      tick(2);
   endtask
   task automatic summarize();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      {reg_wr_i, reg_rd_i, req, en, lin, raw} = 6'h00;
      {addr, persist, wdata, move, vel, rot_u, lin_u} = '0;
      {settle, n_mismatch, n_tests} = '0;
      seed = 32'h7E83;
      sys_rst_i = 1'b1;
      tick(6);
      sys_rst_i = 1'b0;
      rd(find_sup_pkg::ADDR_MAX_MOVE, find_sup_pkg::MAX_MOVE_RESET);  // reset value
      rd(find_sup_pkg::ADDR_VEL_THRESH, 64'h0);  // threshold starts at zero
      rd(16'h0123, 64'h0);  // unmapped reads zero
      // Corners first, then random signed limits on both sides of the range.
      for (int i = 0; i < 12; i++) begin
         t = xs();
         v = (i == 0) ? 64'd90 : (i == 1) ? 64'd91 : {{56{t[7]}}, t[7:0]};
         wr(find_sup_pkg::ADDR_MAX_MOVE, v);
         rd(find_sup_pkg::ADDR_MAX_MOVE, lim_exp(v));  // clamped limit
      end
      // Every unit code on both axis kinds, overflow and in-range values.
      for (int i = 0; i < 8; i++) begin
         lin = i[2];
         rot_u = i[1:0];
         lin_u = i[1:0];
         wr(find_sup_pkg::ADDR_VEL_THRESH, 64'h7FFF_FFFF);
         rd(find_sup_pkg::ADDR_VEL_THRESH, ceil_exp(lin, rot_u));  // unit ceiling
         t = xs() & 32'hFF;
         wr(find_sup_pkg::ADDR_VEL_THRESH, {32'h0, t});
         v = ({32'h0, t} > ceil_exp(lin, rot_u)) ? ceil_exp(lin, rot_u) : {32'h0, t};
         rd(find_sup_pkg::ADDR_VEL_THRESH, v);  // within range
      end
      en = 1'b1;
      arm();
      chk(st, 64'h0);  // refused while enabled
      en = 1'b0;
      arm();
      chk(st, 64'h1);  // armed when idle
      wr(find_sup_pkg::ADDR_CANCEL, {xs(), xs()});
      tick(1);
      chk(st, 64'h0);  // cancel to idle
      en = 1'b1;
      tick(4);
      chk(fact, 64'h0);  // request dropped
      en = 1'b0;
      // Cancel in mid-find for either feedback setting.
      settle = 8'hFF;
      for (int l = 0; l < 2; l++) begin
         lin = l[0];
         arm();
         en = 1'b1;
         tick(3);
         chk(fact, 64'h1);  // runs at enable
         wr(find_sup_pkg::ADDR_CANCEL, 64'h0);
         tick(1);
         chk(st, 64'h0);  // same for any feedback
         chk(fact, 64'h0);  // stops at once
         en = 1'b0;
         tick(1);
      end
      wr(find_sup_pkg::ADDR_MAX_MOVE, 64'd20);
      move = 64'sd20;
      arm();
      en = 1'b1;
      tick(8);
      chk(fault, 64'h0);  // at the limit
      move = -64'sd21;
      tick(3);
      chk(fault, 64'h1);  // beyond the limit
      chk(st, 64'h0);  // fault ends the run
      en = 1'b0;
      move = 64'sd0;
      settle = 8'h00;
      arm();
      chk(fault, 64'h0);  // new request taken
      en = 1'b1;
      tick(6);
      chk(st, 64'h3);  // armed run completes
      // Monitoring in the found state with a rotary threshold of 100.
      lin = 1'b0;
      rot_u = 2'd0;
      wr(find_sup_pkg::ADDR_VEL_THRESH, 64'd100);
      persist = 16'h0001;
      vel = -32'sd100;
      tick(4);
      chk(mact, 64'h0);  // not exceeded
      vel = -32'sd101;
      tick(2);
      chk(mact, 64'h1);  // reverse motion counts
      raw = 1'b1;
      tick(3);
      chk(merr, 64'h0);  // before persist time
      tick(4);
      chk(merr, 64'h1);  // after persist time
      persist = 16'h0000;
      tick(2);
      chk(mact, 64'h0);  // zero disables
      wr(find_sup_pkg::ADDR_CANCEL, 64'h0);
      tick(1);
      chk(st, 64'h0);  // cancel from found
      // A reset after the cancel from found restores the movement limit to its reset value.
      sys_rst_i = 1'b1;
      tick(2);
      sys_rst_i = 1'b0;
      rd(find_sup_pkg::ADDR_MAX_MOVE, find_sup_pkg::MAX_MOVE_RESET);  // reset value
      chk(st, 64'h0);  // idle after reset
      summarize();
   end
endmodule
